// File: logic/cpm_pkg.sv
// Constants, register map and state type of the privilege and mode unit.
// Assumes a single 50 MHz clock domain and one AHB-Lite master.
package cpm_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [11:0] CPM_OFF_CTRL = 12'h000;
  localparam logic [11:0] CPM_OFF_STATUS = 12'h004;
  localparam logic [11:0] CPM_OFF_EXC = 12'h008;
  localparam logic [11:0] CPM_OFF_INSN = 12'h00C;
  localparam logic [11:0] CPM_OFF_REGSEL = 12'h010;
  localparam logic [11:0] CPM_OFF_REGDATA = 12'h014;
  localparam logic [11:0] CPM_OFF_EXSTAT = 12'h018;
  localparam logic [11:0] CPM_OFF_UAADDR = 12'h01C;
  localparam logic [11:0] CPM_OFF_UADATA = 12'h020;
  localparam logic [11:0] CPM_OFF_IRQSTAT = 12'h024;
  localparam logic [11:0] CPM_OFF_IRQMASK = 12'h028;
  localparam logic [6:0] CPM_SRAM_WIN = 7'h02; // 0x040..0x05F
  localparam logic [1:0] CPM_BB_WIN = 2'h1; // 0x400..0x7FF

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CPM_CT_USER = 0;
  localparam int CPM_CT_ALT = 1;
  localparam int CPM_ST_HANDLER = 0;
  localparam int CPM_ST_PRIV = 1;
  localparam int CPM_ST_PSP = 2;
  localparam int CPM_ST_INSOK = 3;
  localparam int CPM_ST_REGION = 4;
  localparam int CPM_EX_ENTER = 0;
  localparam int CPM_EX_LEAVE = 1;
  localparam int CPM_IN_ENC32 = 4;
  localparam int CPM_IN_HIOK = 5;
  localparam int CPM_IN_LEGACY = 6;
  localparam int CPM_IN_RESTR = 7;
  localparam int CPM_EXS_TBIT = 24;
  localparam int CPM_EV_PRIV = 0;
  localparam int CPM_EV_DEC = 1;
  localparam int CPM_EV_STATE = 2;

  // ****************************************
  // Core register indices and regions
  // ****************************************
  localparam logic [3:0] CPM_IDX_HI_LO = 4'h8;
  localparam logic [3:0] CPM_IDX_HI_HI = 4'hC;
  localparam logic [3:0] CPM_IDX_SP = 4'hD;
  localparam logic [3:0] CPM_IDX_PC = 4'hF;
  localparam logic [31:0] CPM_SP_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] CPM_PC_MASK = 32'hFFFF_FFFE;
  localparam logic [1:0] CPM_RG_CODE = 2'h0;
  localparam logic [1:0] CPM_RG_SRAM = 2'h1;
  localparam logic [1:0] CPM_RG_PERIPH = 2'h2;
  localparam logic [1:0] CPM_RG_SYSTEM = 2'h3;

  typedef struct packed {
    logic [1:0] ctrl;
    logic handler;
    logic priv;
    logic psp_sel;
    logic [15:0][31:0] rf;
    logic [31:0] process_stack_pointer;
    logic [7:0][31:0] sram;
    logic [3:0] sel;
    logic [31:0] ua;
    logic ins_ok;
    logic [2:0] ists;
    logic [2:0] imask;
    logic irq;
    logic fault;
    logic hrdy;
    logic [31:0] rdata;
    logic aph_v;
    logic aph_w;
    logic [11:0] aph_a;
  } cpm_state_s;
endpackage

// File: logic/cpm_mode_ctrl.sv
// Privilege level, thread/handler mode, banked stack pointers, core
// register file, bit-band SRAM and unaligned access, over AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, this slave alone.
`timescale 1ns/1ps
module cpm_mode_ctrl
  import cpm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic fault,
  output logic handler_mode,
  output logic privileged,
  output logic psp_sel
);
  import cpm_pkg::*;

  cpm_state_s q;
  cpm_state_s n;
  logic [2:0] ev;
  logic [2:0] clr;
  logic enter;
  logic leave;
  logic wr;
  logic [31:0] wd;
  logic is_hi;

  // ****************************************
  // Helper functions
  // ****************************************
  // Region of a flat 32-bit address, top three bits
  function automatic logic [1:0] region_of(input logic [31:0] a);
    case (a[31:29])
      3'h0: region_of = CPM_RG_CODE;
      3'h1: region_of = CPM_RG_SRAM;
      3'h2: region_of = CPM_RG_PERIPH;
      default: region_of = CPM_RG_SYSTEM;
    endcase
  endfunction

  // Word from any byte of the SRAM, wrapping at its end
  function automatic logic [31:0] ua_rd(input logic [255:0] f, input logic [4:0] b);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[8*i +: 8] = f[{5'(b + 5'(i)), 3'h0} +: 8];
    end
    return r;
  endfunction

  function automatic logic [255:0] ua_wr(input logic [255:0] f, input logic [4:0] b,
                                         input logic [31:0] d);
    logic [255:0] r;
    r = f;
    for (int i = 0; i < 4; i++) begin
      r[{5'(b + 5'(i)), 3'h0} +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // Read value of one register from a given state
  function automatic logic [31:0] rd_fn(input cpm_state_s s, input logic [11:0] a);
    logic [31:0] r;
    logic [255:0] f;
    r = '0;
    f = s.sram;
    case (a)
      CPM_OFF_CTRL: begin
        r[CPM_CT_USER] = s.ctrl[CPM_CT_USER];
        r[CPM_CT_ALT] = s.ctrl[CPM_CT_ALT] & ~s.handler;
      end
      CPM_OFF_STATUS: begin
        r[CPM_ST_HANDLER] = s.handler;
        r[CPM_ST_PRIV] = s.priv;
        r[CPM_ST_PSP] = s.psp_sel;
        r[CPM_ST_INSOK] = s.ins_ok;
        r[CPM_ST_REGION +: 2] = region_of(s.ua);
      end
      CPM_OFF_REGSEL: r[3:0] = s.sel;
      CPM_OFF_REGDATA: begin
        // Banked view of the stack pointer
        if (s.sel == CPM_IDX_SP && s.psp_sel) begin
          r = s.process_stack_pointer;
        end else begin
          r = s.rf[s.sel];
        end
      end
      CPM_OFF_EXSTAT: r[CPM_EXS_TBIT] = 1'b1;
      CPM_OFF_UAADDR: r = s.ua;
      CPM_OFF_UADATA: r = ua_rd(f, s.ua[4:0]);
      CPM_OFF_IRQSTAT: r[2:0] = s.ists;
      CPM_OFF_IRQMASK: r[2:0] = s.imask;
      default: begin
        if (a[11:5] == CPM_SRAM_WIN) begin
          r = s.sram[a[4:2]];
        end else if (a[11:10] == CPM_BB_WIN) begin
          r[0] = s.sram[a[9:7]][a[6:2]];
        end
      end
    endcase
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  // Data-phase write first, then events, then the read for the new
  // address phase, so a read right after a write sees the new value.
  always_comb begin
    n = q;
    ev = '0;
    clr = '0;
    enter = 1'b0;
    leave = 1'b0;
    wr = q.aph_v & q.aph_w;
    wd = hwdata;
    // Decoded once here; only the instruction write uses it
    is_hi = (wd[3:0] >= CPM_IDX_HI_LO) && (wd[3:0] <= CPM_IDX_HI_HI);
    n.fault = 1'b0;
    if (wr) begin
      case (q.aph_a)
        CPM_OFF_CTRL: begin
          if (!q.priv) begin
            ev[CPM_EV_PRIV] = 1'b1;
          end else begin
            // Privileged writes land; the alternate bit only in thread mode
            n.ctrl[CPM_CT_USER] = wd[CPM_CT_USER];
            if (!q.handler) begin
              n.ctrl[CPM_CT_ALT] = wd[CPM_CT_ALT];
            end
          end
        end
        CPM_OFF_EXC: begin
          enter = wd[CPM_EX_ENTER];
          leave = wd[CPM_EX_LEAVE] & q.handler;
        end
        CPM_OFF_INSN: begin
          if (wd[CPM_IN_RESTR] && !q.priv) begin
            ev[CPM_EV_PRIV] = 1'b1;
            n.ins_ok = 1'b0;
          end else if (wd[CPM_IN_LEGACY]) begin
            ev[CPM_EV_DEC] = 1'b1;
            n.ins_ok = 1'b0;
          end else if (!wd[CPM_IN_ENC32] && is_hi && !wd[CPM_IN_HIOK]) begin
            ev[CPM_EV_DEC] = 1'b1;
            n.ins_ok = 1'b0;
          end else begin
            n.ins_ok = 1'b1; // Low registers reachable unless restricted at user level or legacy encoding
          end
        end
        CPM_OFF_REGSEL: n.sel = wd[3:0];
        CPM_OFF_REGDATA: begin
          // Full 32-bit entries
          if (q.sel == CPM_IDX_SP) begin
            if (q.psp_sel) begin
              n.process_stack_pointer = wd & CPM_SP_MASK;
            end else begin
              n.rf[CPM_IDX_SP] = wd & CPM_SP_MASK;
            end
          end else if (q.sel == CPM_IDX_PC) begin
            n.rf[CPM_IDX_PC] = wd & CPM_PC_MASK;
          end else begin
            n.rf[q.sel] = wd;
          end
        end
        CPM_OFF_EXSTAT: begin
          if (!wd[CPM_EXS_TBIT]) begin
            ev[CPM_EV_STATE] = 1'b1;
          end
        end
        CPM_OFF_UAADDR: n.ua = wd;
        CPM_OFF_UADATA: n.sram = ua_wr(q.sram, q.ua[4:0], wd);
        CPM_OFF_IRQSTAT: clr = wd[2:0];
        CPM_OFF_IRQMASK: n.imask = wd[2:0];
        default: begin
          if (q.aph_a[11:5] == CPM_SRAM_WIN) begin
            n.sram[q.aph_a[4:2]] = wd;
          end else if (q.aph_a[11:10] == CPM_BB_WIN) begin
            // One-cycle read-modify-write of a single bit
            n.sram[q.aph_a[9:7]][q.aph_a[6:2]] = wd[0];
          end
        end
      endcase
    end
    // A fault is an exception and enters the handler
    if (|ev) begin
      n.fault = 1'b1;
      enter = 1'b1;
    end
    // Entry beats return when both come together
    if (enter) begin
      n.handler = 1'b1;
    end else if (leave) begin
      n.handler = 1'b0; // Thread state kept in ctrl is restored
    end
    // Privilege and stack follow mode and control
    n.priv = n.handler | ~n.ctrl[CPM_CT_USER];
    n.psp_sel = ~n.handler & n.ctrl[CPM_CT_USER];
    // Set wins over a write-one clear
    n.ists = (q.ists & ~clr) | ev;
    n.irq = |(n.ists & n.imask);
    // No wait states: every access completes in its data phase
    n.hrdy = 1'b1;
    // Address phase capture
    n.aph_v = hsel & htrans[1] & hready;
    n.aph_w = hwrite;
    n.aph_a = {haddr[11:2], 2'h0};
    // Read data is latched at the address phase edge and then stands
    // through the data phase, so hrdata is a plain register
    if (hsel && htrans[1] && hready && !hwrite) begin
      n.rdata = rd_fn(n, n.aph_a);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Clean start: privileged thread on main stack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.priv <= 1'b1;
      q.hrdy <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  // Outputs are fields of the state register; the response code is
  // the one constant, as no transfer is ever refused
  assign hreadyout = q.hrdy;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign irq = q.irq;
  assign fault = q.fault;
  assign handler_mode = q.handler;
  assign privileged = q.priv;
  assign psp_sel = q.psp_sel;

  // ****************************************
  // Assertions
  // ****************************************
  // Data-phase write strobes, one per register that the checks watch
  logic wr_ctrl;
  logic wr_insn;
  logic wr_exs;
  logic wr_ist;
  assign wr_ctrl = ce && q.aph_v && q.aph_w && q.aph_a == CPM_OFF_CTRL;
  assign wr_insn = ce && q.aph_v && q.aph_w && q.aph_a == CPM_OFF_INSN;
  assign wr_exs = ce && q.aph_v && q.aph_w && q.aph_a == CPM_OFF_EXSTAT;
  assign wr_ist = ce && q.aph_v && q.aph_w && q.aph_a == CPM_OFF_IRQSTAT;

  // One clock domain, so one default clock and reset serve all checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  priv_handler_a: assert property (handler_mode |-> privileged && !psp_sel)
    else $error("handler mode without privilege");
  user_fault_a: assert property (wr_ctrl && !privileged |=> fault && handler_mode)
    else $error("user control write did not fault");
  priv_ok_a: assert property (wr_ctrl && privileged |=> !fault)
    else $error("privileged write faulted");
  hi_reg_a: assert property (wr_insn && privileged && !hwdata[CPM_IN_ENC32]
    && !hwdata[CPM_IN_HIOK] && !hwdata[CPM_IN_LEGACY]
    && hwdata[3:0] >= CPM_IDX_HI_LO && hwdata[3:0] <= CPM_IDX_HI_HI
    |=> fault && !q.ins_ok)
    else $error("high register reached by plain 16-bit form");
  align_a: assert property (q.rf[CPM_IDX_SP][1:0] == 2'h0 && q.process_stack_pointer[1:0] == 2'h0
    && q.rf[CPM_IDX_PC][0] == 1'b0)
    else $error("stack or program counter misaligned");
  tbit_a: assert property (wr_exs && !hwdata[CPM_EXS_TBIT] |=> fault ##1 !fault)
    else $error("clearing state bit did not fault once");
  user_psp_a: assert property (!handler_mode && !privileged |-> psp_sel)
    else $error("user thread not on process stack");
  entry_a: assert property ($rose(handler_mode) |-> privileged && !psp_sel
    && q.ctrl == $past(q.ctrl))
    else $error("handler entry state wrong");
  irq_lvl_a: assert property (fault && q.imask[CPM_EV_PRIV] && $past(ev[CPM_EV_PRIV]) |-> irq)
    else $error("unmasked event gave no interrupt");

  // Return to thread takes level and stack back from control
  return_a: assert property ($fell(handler_mode) |-> privileged == !q.ctrl[CPM_CT_USER]
    && psp_sel == q.ctrl[CPM_CT_USER])
    else $error("thread state not restored on return");
  priv_thread_a: assert property (!handler_mode && privileged |-> !psp_sel)
    else $error("privileged thread on process stack");

  // Decoder outcomes show one cycle after the data phase
  user_restr_a: assert property (wr_insn && !privileged && hwdata[CPM_IN_RESTR]
    |=> fault && handler_mode)
    else $error("restricted instruction ran at user level");
  legacy_a: assert property (wr_insn && hwdata[CPM_IN_LEGACY] |=> fault && !q.ins_ok)
    else $error("legacy encoding accepted");
  low_reg_a: assert property (wr_insn && (privileged || !hwdata[CPM_IN_RESTR])
    && !hwdata[CPM_IN_LEGACY] && hwdata[3:0] < CPM_IDX_HI_LO |=> !fault && q.ins_ok)
    else $error("low register refused");

  // Writes that must leave the state alone
  ctrl_alt_a: assert property (wr_ctrl && handler_mode
    |=> q.ctrl[CPM_CT_ALT] == $past(q.ctrl[CPM_CT_ALT]))
    else $error("alternate stack bit written in handler");
  tbit_keep_a: assert property (wr_exs && hwdata[CPM_EXS_TBIT] |=> !fault)
    else $error("setting state bit faulted");

  // Status bits are sticky: only a status write may clear any
  ists_keep_a: assert property (!wr_ist |=> (q.ists & $past(q.ists)) == $past(q.ists))
    else $error("status bit lost without a clear");

  // Main scenarios
  user_fault_c: cover property (wr_ctrl && !privileged ##1 fault);
  handler_return_c: cover property (handler_mode ##[1:20] !handler_mode && psp_sel);
  irq_c: cover property ($rose(irq));
  fault_entry_c: cover property (wr_insn ##1 fault && handler_mode);
  bitband_c: cover property (q.aph_v && q.aph_w && q.aph_a[11:10] == CPM_BB_WIN);
endmodule

// File: dv/cpm_bus_master.sv
// Bus master model for the privilege and mode unit's register port.
// Assumes the single slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module cpm_bus_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic ce,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  // ****************************************
  // Idle bus at time zero
  // ****************************************
  initial begin
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // ****************************************
  // One single word transfer
  // ****************************************
  // Holds each phase until hready, no assumed latency
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata; // Reads toggle data so stale values never match
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    #1;
  endtask
endmodule

// File: dv/test_cpm_mode_ctrl.sv
// Self-checking bench for the privilege and mode unit.
// Assumes the bus master model drives every bus input but hready, which is hreadyout fed back.
`timescale 1ns/1ps
module test_cpm_mode_ctrl;
  import cpm_pkg::*;
  logic hclk;
  logic hresetn;
  wire ce, hsel, hwrite, hreadyout, hresp, irq, fault, handler_mode, privileged, psp_sel;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  int failures = 0;
  int checks = 0;
  int nf = 0;
  logic [31:0] v;
  logic [31:0] ins [8] = '{32'h80, 32'h03, 32'h13, 32'h19, 32'h29, 32'h09, 32'h0C, 32'h50};
  bit ok [8] = '{1, 1, 1, 1, 1, 0, 0, 0};

  cpm_mode_ctrl uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .fault(fault), .handler_mode(handler_mode),
    .privileged(privileged), .psp_sel(psp_sel));
  cpm_bus_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  // ****************************************
  // Clock, fault pulse count, watchdog
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (fault === 1'b1) nf++;
  // Whole run is about 130 cycles
  initial begin
    #200000;
    failures++;
    finish_test;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(1'b1, {20'h0, a}, d, q);
  endtask
  task automatic r(input logic [11:0] a, output logic [31:0] q);
    m.xfer(1'b0, {20'h0, a}, 32'h0, q);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    r(a, q);
    chk($sformatf("read %h", a), e, q);
  endtask
  task automatic mode(input logic h, input logic p, input logic s);
    chk("handler_mode", {31'h0, h}, {31'h0, handler_mode});
    chk("privileged", {31'h0, p}, {31'h0, privileged});
    chk("psp_sel", {31'h0, s}, {31'h0, psp_sel});
  endtask
  task finish_test;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    mode(0, 1, 0);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("hresp", 32'h0, {31'h0, hresp});
    rc(CPM_OFF_STATUS, 32'h2);
    rc(CPM_OFF_CTRL, 32'h0);
    rc(CPM_OFF_EXSTAT, 32'h0100_0000);
    rc(12'h030, 32'h0);
    // Register file width, alignment of stack and program counter
    w(CPM_OFF_REGSEL, 32'h0);
    w(CPM_OFF_REGDATA, 32'hFFFF_FFFF);
    rc(CPM_OFF_REGDATA, 32'hFFFF_FFFF);
    w(CPM_OFF_REGSEL, {28'h0, CPM_IDX_PC});
    w(CPM_OFF_REGDATA, 32'h0000_1235);
    rc(CPM_OFF_REGDATA, 32'h0000_1234);
    w(CPM_OFF_REGSEL, {28'h0, CPM_IDX_SP});
    w(CPM_OFF_REGDATA, 32'h2000_0FFF);
    rc(CPM_OFF_REGDATA, 32'h2000_0FFC);
    // User thread, then faults back into handler
    w(CPM_OFF_IRQMASK, 32'h7);
    w(CPM_OFF_CTRL, 32'h1);
    mode(0, 0, 1);
    rc(CPM_OFF_REGDATA, 32'h0);
    w(CPM_OFF_INSN, 32'h80);
    mode(1, 1, 0);
    rc(CPM_OFF_IRQSTAT, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    rc(CPM_OFF_REGDATA, 32'h2000_0FFC);
    w(CPM_OFF_CTRL, 32'h3);
    rc(CPM_OFF_CTRL, 32'h1);
    w(CPM_OFF_EXC, 32'h2);
    mode(0, 0, 1);
    w(CPM_OFF_CTRL, 32'h0);
    mode(1, 1, 0);
    w(CPM_OFF_CTRL, 32'h0);
    w(CPM_OFF_EXC, 32'h2);
    mode(0, 1, 0);
    w(CPM_OFF_IRQSTAT, 32'h7);
    chk("irq", 32'h0, {31'h0, irq});
    w(CPM_OFF_EXC, 32'h1);
    mode(1, 1, 0);
    w(CPM_OFF_EXC, 32'h2);
    // Decoder outcomes, each fault returned and cleared
    for (int i = 0; i < 8; i++) begin
      w(CPM_OFF_INSN, ins[i]);
      r(CPM_OFF_STATUS, v);
      chk("insn ok", {31'h0, ok[i]}, {31'h0, v[CPM_ST_INSOK]});
      chk("irq", {31'h0, ~ok[i]}, {31'h0, irq});
      if (!ok[i]) begin
        w(CPM_OFF_EXC, 32'h2);
        w(CPM_OFF_IRQSTAT, 32'h7);
      end
    end
    w(CPM_OFF_EXSTAT, 32'h0);
    rc(CPM_OFF_IRQSTAT, 32'h4);
    w(CPM_OFF_EXC, 32'h2);
    w(CPM_OFF_IRQSTAT, 32'h7);
    // Unaligned word, region probe, bit-band alias
    w(12'h040, 32'h3322_1100);
    w(12'h044, 32'h7766_5544);
    w(CPM_OFF_UAADDR, 32'h2000_0001);
    rc(CPM_OFF_UADATA, 32'h4433_2211);
    r(CPM_OFF_STATUS, v);
    chk("region", {30'h0, CPM_RG_SRAM}, {30'h0, v[5:4]});
    w(12'h414, 32'h1);
    rc(12'h040, 32'h3322_1120);
    rc(12'h414, 32'h1);
    chk("fault pulses", 32'd6, nf);
    finish_test;
  end
endmodule
